// ==== common/pport_regs.vh ====
`ifndef PPORT_REGS_VH
`define PPORT_REGS_VH

// ----------------------------------------------------------------
// transfer mode codes (one-hot select input)
// ----------------------------------------------------------------
`define MODE_W          4
`define MODE_STANDARD   4'h1
`define MODE_VENDOR     4'h2
`define MODE_BIDIR      4'h4
`define MODE_COPIER     4'h8

// ----------------------------------------------------------------
// handshake timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   5
`define STROBE_NS       500
// 500 ns at 5 ns per cycle, sized to the counter width
`define STROBE_CYC      16'h0064
`define SETUP_NS        500
`define SETUP_CYC       16'h0064
`define CNT_W           16

`endif

// ==== logic/pin_sync.v ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// two-stage synchroniser for a group of pins
// ----------------------------------------------------------------
module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk_sys,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] async_in,
	input  wire [WIDTH-1:0] rst_val,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;

	// first stage feeds only the second
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_reg <= rst_val;
			sync_out <= rst_val;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // pin_sync

// ==== logic/pport_pins.v ====
// Contract
// R1 - standard, vendor, bidir write drive strobe, busy
// R2 - copier mode drives strobes only when direction low
// R3 - fault pin carries dma direction in copier mode
// R4 - peripheral confirms direction on paper-end line
// R5 - bidir read: autofeed low shows host ready
// R6 - bidir write holds autofeed high
// R7 - bidir init line shows direction, high write
// R8 - otherwise init line is printer reset, low
// R9 - standard mode: select-in low on reverse data
// R10 - vendor mode: select-in is no-ink input
// R11 - bidir mode keeps select-in deasserted
// R12 - peripheral pulls acknowledge low per transfer
// R13 - data direction control follows transfer direction
// R14 - dma request driven low to request service
// R15 - host answers dma request with grant low
// R16 - terminal count marks final dma transfer
// R17 - host reads: read strobe low with select
// R18 - host writes: write strobe low with select
// R19 - terminal count with grant ends dma sequence
// R20 - all peripheral handshake inputs are synchronised; busy_line_in and port_strobe_line_in_n are neither used nor synchronised
`timescale 1ns/10ps
`include "pport_regs.vh"

module pport_pins #(
	parameter [`CNT_W-1:0] STROBE_CYC = `STROBE_CYC,
	parameter [`CNT_W-1:0] SETUP_CYC  = `SETUP_CYC
) (
	input  wire              clk_sys,
	input  wire              sys_rst,
	// control
	input  wire [`MODE_W-1:0] mode_sel,
	input  wire              dir_read,
	input  wire              dma_direction_flag,
	input  wire              printer_reset,
	input  wire              dma_enable,
	input  wire [7:0]        tx_data,
	input  wire              tx_valid,
	output reg               tx_ready,
	output reg  [7:0]        rx_data,
	output reg               rx_valid,
	output reg               dma_done,
	output reg               no_ink,
	output reg               printer_fault,
	output reg               paper_end,
	output reg               online,
	output reg               dir_confirm_fwd,
	// host bus dma
	output reg               dma_request_out_n,
	input  wire              dma_grant_in_n,
	input  wire              terminal_count_in,
	// printer side
	input  wire [7:0]        port_data_in,
	output reg  [7:0]        port_data_out,
	output reg               port_data_oe_n,
	output reg               port_data_dir_ctl,
	input  wire              ack_line_n,
	input  wire              paper_end_line,
	input  wire              online_status_line,
	input  wire              fault_line_in_n,
	output reg               fault_line_out,
	output reg               fault_line_oe_n,
	input  wire              busy_line_in,
	output reg               busy_line_out,
	output reg               busy_line_oe_n,
	input  wire              port_strobe_line_in_n,
	output reg               port_strobe_line_out_n,
	output reg               port_strobe_line_oe_n,
	output reg               autofeed_line_n,
	output reg               init_line_n,
	input  wire              select_in_line_in_n,
	output reg               select_in_line_out_n,
	output reg               select_in_line_oe_n
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	wire [7:0] s_bus;
	wire       s_ack_n;
	wire       s_paper;
	wire       s_online;
	wire       s_fault_n;
	wire       s_selin_n;
	wire       s_grant_n;
	wire       s_last;

	pin_sync #(.WIDTH(8)) u_sync_data (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.async_in(port_data_in),
		.rst_val (8'hFF),
		.sync_out(s_bus)
	); // R20

	pin_sync #(.WIDTH(7)) u_sync_ctl (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.async_in({ack_line_n, paper_end_line, online_status_line, fault_line_in_n,
			select_in_line_in_n, dma_grant_in_n, terminal_count_in}),
		.rst_val (7'h7E),
		.sync_out({s_ack_n, s_paper, s_online, s_fault_n, s_selin_n, s_grant_n, s_last})
	); // R20

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire m_std    = (mode_sel == `MODE_STANDARD);
	wire m_vendor = (mode_sel == `MODE_VENDOR);
	wire m_bidir  = (mode_sel == `MODE_BIDIR);
	wire m_copier = (mode_sel == `MODE_COPIER);
	// copier mode: direction flag low means host sends
	wire reading  = m_copier ? dma_direction_flag : dir_read;
	wire drive_strobe = m_copier ? ~dma_direction_flag : ~reading; // R1 R2

	// ------------------------------------------------------------
	// transfer state machine
	// ------------------------------------------------------------
	localparam [4:0] S_IDLE  = 5'h01;
	localparam [4:0] S_SETUP = 5'h02;
	localparam [4:0] S_STRB  = 5'h04;
	localparam [4:0] S_WACK  = 5'h08;
	localparam [4:0] S_WREL  = 5'h10;

	reg [4:0]        state_reg;
	reg [4:0]        state_next;
	reg [`CNT_W-1:0] cnt_reg;
	reg [`CNT_W-1:0] cnt_next;
	reg [7:0]        hold_reg;
	reg              dma_active_reg;
	reg              last_reg;

	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			S_IDLE: begin
				cnt_next = SETUP_CYC;
				if (!reading && tx_valid)
					state_next = S_SETUP;
				else if (reading && !s_ack_n)
					state_next = S_WREL;   // R12
			end
			S_SETUP: begin
				if (cnt_reg <= 16'h0001) begin
					state_next = S_STRB;
					cnt_next   = STROBE_CYC;
				end else
					cnt_next = cnt_reg - 16'h0001;
			end
			S_STRB: begin
				if (cnt_reg <= 16'h0001)
					state_next = S_WACK;
				else
					cnt_next = cnt_reg - 16'h0001;
			end
			S_WACK: begin
				if (!s_ack_n)
					state_next = S_WREL;   // R12
			end
			S_WREL: begin
				if (s_ack_n)
					state_next = S_IDLE;
			end
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 16'h0000;
			hold_reg  <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (state_reg == S_IDLE && !reading && tx_valid)
				hold_reg <= tx_data;
		end
	end

	// ------------------------------------------------------------
	// dma sequencing
	// ------------------------------------------------------------
	// request only while a transfer slot is free
	wire want_dma = dma_enable && m_copier && (state_reg == S_IDLE);
	wire grant    = ~s_grant_n;
	wire word_end = (state_next == S_IDLE) && (state_reg == S_WREL);

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			dma_active_reg <= 1'b0;
			last_reg       <= 1'b0;
		end else begin
			if (!dma_enable)
				dma_active_reg <= 1'b0;
			else if (grant && s_last)
				dma_active_reg <= 1'b0;   // R19
			else if (want_dma && !last_reg)
				dma_active_reg <= 1'b1;
			if (!dma_enable)
				last_reg <= 1'b0;
			else if (grant && s_last)
				last_reg <= 1'b1;         // R19
		end
	end

	// ------------------------------------------------------------
	// registered pin and status outputs
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_ready               <= 1'b0;
			rx_data                <= 8'h00;
			rx_valid               <= 1'b0;
			dma_done               <= 1'b0;
			no_ink                 <= 1'b0;
			printer_fault          <= 1'b0;
			paper_end              <= 1'b0;
			online                 <= 1'b0;
			dir_confirm_fwd        <= 1'b0;
			dma_request_out_n      <= 1'b1;
			port_data_out          <= 8'h00;
			port_data_oe_n         <= 1'b1;
			port_data_dir_ctl      <= 1'b0;
			fault_line_out         <= 1'b0;
			fault_line_oe_n        <= 1'b1;
			busy_line_out          <= 1'b0;
			busy_line_oe_n         <= 1'b1;
			port_strobe_line_out_n <= 1'b1;
			port_strobe_line_oe_n  <= 1'b1;
			autofeed_line_n        <= 1'b1;
			init_line_n            <= 1'b0;
			select_in_line_out_n   <= 1'b1;
			select_in_line_oe_n    <= 1'b1;
		end else begin
			tx_ready <= (state_reg == S_IDLE) && !reading && !(tx_valid && tx_ready);
			rx_valid <= reading && (state_reg == S_IDLE) && !s_ack_n;
			if (reading && (state_reg == S_IDLE) && !s_ack_n)
				rx_data <= s_bus;
			dma_done        <= grant && s_last && dma_active_reg; // R19
			no_ink          <= m_vendor && !s_selin_n;           // R10
			printer_fault   <= !m_copier && !s_fault_n;
			paper_end       <= s_paper;
			online          <= s_online;
			dir_confirm_fwd <= m_bidir && s_paper;               // R4
			// drops after terminal count or on a word in flight
			dma_request_out_n <= ~(want_dma && !last_reg && !(grant && s_last)); // R14 R19
			// data bus: drive only when host sends
			port_data_out     <= hold_reg;
			port_data_oe_n    <= reading;
			port_data_dir_ctl <= ~reading;                       // R13
			// strobe is low in S_STRB only; busy is high through S_STRB and S_WACK
			port_strobe_line_oe_n  <= ~drive_strobe;              // R1 R2
			busy_line_oe_n         <= ~drive_strobe;              // R1 R2
			port_strobe_line_out_n <= ~(state_reg == S_STRB);     // R1
			busy_line_out          <= (state_reg == S_STRB) || (state_reg == S_WACK);
			fault_line_oe_n <= ~m_copier;                         // R3
			fault_line_out  <= dma_direction_flag;                // R3
			// autofeed: ready in bidir read, released after ack
			if (m_bidir)
				autofeed_line_n <= reading ? ~(state_reg == S_IDLE) : 1'b1; // R5 R6
			else
				autofeed_line_n <= 1'b1;
			if (m_bidir)
				init_line_n <= ~reading;                          // R7
			else
				init_line_n <= ~printer_reset;                    // R8
			// select-in: vendor mode turns it around as input
			select_in_line_oe_n  <= m_vendor;                     // R10
			if (m_std)
				select_in_line_out_n <= ~reading;                 // R9
			else
				select_in_line_out_n <= 1'b1;                     // R11
		end
	end
endmodule // pport_pins

// ==== verification/pport_pins_assertions.sv ====
`timescale 1ns/10ps
`include "pport_regs.vh"
module pport_pins_assertions (
	input	wire			clk_sys,
	input	wire			sys_rst,
	input	wire	[`MODE_W-1:0]	mode_sel,
	input	wire			dir_read,
	input	wire			dma_direction_flag,
	input	wire			printer_reset,
	input	wire			dma_done,
	input	wire			dma_request_out_n,
	input	wire			port_data_oe_n,
	input	wire			port_data_dir_ctl,
	input	wire			fault_line_out,
	input	wire			fault_line_oe_n,
	input	wire			busy_line_oe_n,
	input	wire			port_strobe_line_oe_n,
	input	wire			port_strobe_line_out_n,
	input	wire			busy_line_out,
	input	wire			autofeed_line_n,
	input	wire			init_line_n,
	input	wire			select_in_line_out_n,
	input	wire			select_in_line_oe_n
);
// ----------------------------------------
// pin roles per mode
// ----------------------------------------
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (sys_rst);
// three settled cycles let the output registers follow a mode change
wire cp = mode_sel == `MODE_COPIER;
wire bd = mode_sel == `MODE_BIDIR;
wire sd = mode_sel == `MODE_STANDARD;
fault_dir_a: assert property ((cp && $stable(dma_direction_flag)) [*3] |->
	!fault_line_oe_n && fault_line_out == dma_direction_flag) else $error("fault pin");
copier_quiet_a: assert property ((cp && dma_direction_flag) [*3] |->
	port_strobe_line_oe_n && busy_line_oe_n) else $error("strobe driven");
feed_write_a: assert property ((bd && !dir_read) [*3] |-> autofeed_line_n)
	else $error("autofeed low");
init_dir_a: assert property ((bd && $stable(dir_read)) [*3] |-> init_line_n == !dir_read)
	else $error("init dir");
init_reset_a: assert property ((sd && $stable(printer_reset)) [*3] |->
	init_line_n == !printer_reset) else $error("init reset");
selin_bidir_a: assert property (bd [*3] |-> select_in_line_oe_n || select_in_line_out_n)
	else $error("select-in bidir");
selin_vendor_a: assert property ((mode_sel == `MODE_VENDOR) [*3] |-> select_in_line_oe_n)
	else $error("select-in vendor");
selin_rev_a: assert property ((sd && dir_read) [*3] |->
	!select_in_line_oe_n && !select_in_line_out_n) else $error("select-in rev");
data_dir_a: assert property (!port_data_oe_n |-> port_data_dir_ctl)
	else $error("data dir");
dma_end_a: assert property (dma_done |-> ##[0:2] dma_request_out_n)
	else $error("request kept");
busy_strobe_a: assert property (!port_strobe_line_out_n |-> busy_line_out)
	else $error("busy off");
cover property (dma_done);
cover property (!port_strobe_line_oe_n && !busy_line_oe_n);
cover property (bd && dir_read && !autofeed_line_n);
endmodule // pport_pins_assertions

// ==== verification/printer_model.sv ====
`timescale 1ns/10ps
module printer_model (
	input	wire		clk_sys,
	input	wire		strobe_n,
	input	wire		init_n,
	input	wire	[7:0]	bus_in,
	input	wire	[3:0]	slow,
	input	wire		send,
	input	wire	[7:0]	send_byte,
	output	reg		ack_n,
	output	wire		paper_end,
	output	reg	[7:0]	pdata,
	output	reg	[7:0]	got,
	output	reg		got_v
);
// ----------------------------------------
// peripheral handshake
// ----------------------------------------
assign paper_end = init_n;
initial begin
	{ack_n, got_v, pdata, got} = 18'h20000;
	forever begin
		@(posedge clk_sys);
		if (strobe_n === 1'b0 || send) begin
			got <= bus_in;
			got_v <= 1'b0;
			pdata <= send_byte;
			repeat (slow) @(posedge clk_sys);
			ack_n <= 1'b0;
			repeat (8) @(posedge clk_sys);
			ack_n <= 1'b1;
			got_v <= 1'b1;
			@(posedge clk_sys);
			// released bus shows a changed value, not the old byte
			pdata <= ~send_byte;
		end
	end
end
endmodule // printer_model

// ==== verification/pport_pins_bench.sv ====
`timescale 1ns/10ps
`include "pport_regs.vh"
module pport_pins_bench;
// ----------------------------------------
// pins, partner and stimulus
// ----------------------------------------
reg		clk_sys, sys_rst, dir_rd, flag, prst, dma_en, tx_v, gnt_n, last_cnt, flt_n, sel_n, send;
reg		onl_in;
reg	[3:0]	mode, slow;
reg	[7:0]	tx_d, sb;
wire	[7:0]	rx_d, pdo, pdm, got;
wire		tx_rdy, rx_v, done, no_ink, pflt, fwd, req_n, pdo_n, ddir, ack_n, pap_end;
wire		fo, fo_n, bo_n, so_n, so_oe, feed_n, init_n, sto_n, sto_oe, got_v, pend, onl;
// a released strobe floats high; other released pins show the far side's drive
wire		stb = sto_oe ? 1'b1 : sto_n;
wire		fi = fo_n ? flt_n : fo;
wire		si = so_oe ? sel_n : so_n;
wire	[7:0]	bus_pins = pdo_n ? pdm : pdo;
integer		n_mismatch = 0;
integer		total_checks = 0;
pport_pins #(.STROBE_CYC(16'h0002), .SETUP_CYC(16'h0002)) i_dut (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .mode_sel(mode), .dir_read(dir_rd), .dma_direction_flag(flag),
	.printer_reset(prst), .dma_enable(dma_en), .tx_data(tx_d), .tx_valid(tx_v),
	.tx_ready(tx_rdy), .rx_data(rx_d), .rx_valid(rx_v), .dma_done(done), .no_ink(no_ink),
	.printer_fault(pflt), .paper_end(pend), .online(onl), .dir_confirm_fwd(fwd),
	.dma_request_out_n(req_n), .dma_grant_in_n(gnt_n), .terminal_count_in(last_cnt),
	.port_data_in(bus_pins), .port_data_out(pdo), .port_data_oe_n(pdo_n),
	.port_data_dir_ctl(ddir),
	.ack_line_n(ack_n), .paper_end_line(pap_end), .online_status_line(onl_in),
	.fault_line_in_n(fi), .fault_line_out(fo), .fault_line_oe_n(fo_n), .busy_line_in(1'b0),
	.busy_line_out(), .busy_line_oe_n(bo_n), .port_strobe_line_in_n(1'b1),
	.port_strobe_line_out_n(sto_n), .port_strobe_line_oe_n(sto_oe),
	.autofeed_line_n(feed_n), .init_line_n(init_n), .select_in_line_in_n(si),
	.select_in_line_out_n(so_n), .select_in_line_oe_n(so_oe));
printer_model i_prn (.clk_sys(clk_sys), .strobe_n(stb), .init_n(init_n), .bus_in(bus_pins),
	.slow(slow), .send(send), .send_byte(sb), .ack_n(ack_n), .paper_end(pap_end),
	.pdata(pdm), .got(got), .got_v(got_v));
task chk(input [7:0] g, input [7:0] e);
	begin
		total_checks = total_checks + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	end
endtask
task wr(input [7:0] b);
	begin
		tx_d = b;
		// a hang here is caught by the watchdog
		while (tx_rdy !== 1'b1) @(negedge clk_sys);
		tx_v = 1'b1;
		@(negedge clk_sys);
		tx_v = 1'b0;
		while (got_v !== 1'b0) @(negedge clk_sys);
		while (got_v !== 1'b1) @(negedge clk_sys);
		chk(got, b);
	end
endtask
task rd(input [7:0] b);
	begin
		sb = b;
		send = 1'b1;
		while (rx_v !== 1'b1) @(negedge clk_sys);
		send = 1'b0;
		chk(rx_d, b);
		repeat (20) @(negedge clk_sys);
	end
endtask
task wrap_up;
	begin
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
endtask
initial begin
	clk_sys = 1'b0;
	forever #2.5 clk_sys = ~clk_sys;
end
initial begin
	#100000;
	n_mismatch = n_mismatch + 1;
	wrap_up;
end
initial begin
	{sys_rst, dir_rd, flag, prst, dma_en, tx_v, last_cnt, send, gnt_n, flt_n, sel_n} = 11'h407;
	{mode, slow, tx_d, sb} = 24'h110000;
	onl_in = 1'b1;
	repeat (8) @(negedge clk_sys);
	chk({init_n, req_n, sto_oe, fo_n}, 8'h07);
	sys_rst = 1'b0;
	repeat (3) @(negedge clk_sys);
	wr(8'hA5);
	wr(8'h5A);
	slow = 4'h9;
	wr(8'h3C);
	dir_rd = 1'b1;
	flt_n = 1'b0;
	prst = 1'b1;
	repeat (4) @(negedge clk_sys);
	chk({so_oe, so_n, pflt, init_n, ddir}, 8'h04);
	rd(8'hC3);
	{dir_rd, flt_n, prst, sel_n, mode} = 8'h02;
	repeat (4) @(negedge clk_sys);
	chk({so_oe, no_ink, init_n}, 8'h07);
	chk({pend, onl, ddir}, 8'h07);
	wr(8'h81);
	{sel_n, mode} = 5'h14;
	repeat (4) @(negedge clk_sys);
	chk({feed_n, init_n, fwd, si}, 8'h0F);
	wr(8'h7E);
	dir_rd = 1'b1;
	repeat (4) @(negedge clk_sys);
	chk({feed_n, init_n, fwd, si}, 8'h01);
	rd(8'h96);
	{dir_rd, mode, dma_en} = 6'h11;
	repeat (4) @(negedge clk_sys);
	chk({req_n, fo_n, fo}, 8'h00);
	wr(8'h42);
	// the host grants only a standing request
	while (req_n !== 1'b0) @(negedge clk_sys);
	{gnt_n, last_cnt} = 2'b01;
	while (done !== 1'b1) @(negedge clk_sys);
	chk(done, 1'b1);
	{gnt_n, last_cnt} = 2'b10;
	repeat (4) @(negedge clk_sys);
	chk(req_n, 1'b1);
	{dma_en, flag} = 2'b01;
	onl_in = 1'b0;
	repeat (4) @(negedge clk_sys);
	chk({fo, fo_n, sto_oe, bo_n, onl}, 8'h16);
	wrap_up;
end
endmodule // pport_pins_bench
bind pport_pins pport_pins_assertions i_chk (.*);
